// >>> src/ipsc_pending.sv
// Interrupt pending set/clear words with AXI4-Lite register slave
//
// Notes on behaviour
// R1 - A one written to bit 2 or 3 of set word 4 makes line 98 or 99 pending.
// R2 - A set write of one leaves a line that is already pending or disabled unchanged.
// R3 - A zero written to any set or clear bit changes nothing.
// R4 - Reading a set or clear bit returns the line's live pending state.
// R5 - A one written to the matching clear bit removes the pending state of that line.
// R6 - Bits 30..14 of clear word 1 map to lines 30..14 and a one clears them.
// R7 - A clear write of one does nothing to a line whose handler is being serviced.
// R8 - Set and clear words read back the same pending vector.
module ipsc_pending
    import ipsc_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclken,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire ipsc_lines_t line_event,
    input wire ipsc_lines_t line_enable,
    input wire ipsc_lines_t line_active,
    output ipsc_lines_t pend_lines,
    output logic irq
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic ipsc_reg_t reg_decode(input logic [ADDR_W-1:0] a);
        ipsc_reg_t r;
        r = REG_NONE;
        unique case (a)
            OFS_SET_WORD1: r = REG_SET1;
            OFS_SET_WORD4: r = REG_SET4;
            OFS_CLR_WORD1: r = REG_CLR1;
            OFS_CLR_WORD4: r = REG_CLR4;
            OFS_EVT_STATUS: r = REG_EVT_STAT;
            OFS_EVT_CLEAR: r = REG_EVT_CLR;
            OFS_EVT_ENABLE: r = REG_EVT_EN;
            default: r = REG_NONE;
        endcase
        return r;
    endfunction

    ipsc_state_t q;
    ipsc_state_t d;
    logic wr_go;
    ipsc_reg_t wr_reg;
    ipsc_reg_t rd_reg;
    logic [DATA_W-1:0] byte_mask;
    logic [DATA_W-1:0] wbits;
    ipsc_lines_t set_req;
    ipsc_lines_t clr_req;
    ipsc_lines_t hw_new;
    ipsc_lines_t set_ok;
    ipsc_lines_t clr_ok;
    ipsc_lines_t clr_blk;
    logic [EVT_W-1:0] evt_new;

    // ------------------------------------------------------------
    // Handshakes, held off while the clock enable is low
    // ------------------------------------------------------------
    assign s_axi_awready = aclken && !q.aw_held && !q.bvalid;
    assign s_axi_wready = aclken && !q.w_held && !q.bvalid;
    assign s_axi_arready = aclken && !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;
    assign pend_lines = q.pend;
    assign irq = q.irq;

    assign wr_go = aclken && q.aw_held && q.w_held && !q.bvalid;
    assign wr_reg = reg_decode(q.waddr);
    assign rd_reg = reg_decode(s_axi_araddr);

    // ------------------------------------------------------------
    // Byte lanes of the held write
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            assign byte_mask[8*g +: 8] = {8{q.wstrb[g]}};
        end
    endgenerate
    // R3 - zeros carry no request
    assign wbits = q.wdata & byte_mask;

    // ------------------------------------------------------------
    // Pending update
    // ------------------------------------------------------------
    always_comb begin
        set_req = '0;
        clr_req = '0;
        if (wr_go) begin
            // R1 - set word 4 covers lines 99..98
            if (wr_reg == REG_SET4) begin
                set_req.w4 = wbits & LINE_MASK_W4;
            end
            if (wr_reg == REG_SET1) begin
                set_req.w1 = wbits & LINE_MASK_W1;
            end
            // R6 - clear word 1 bits map to same line numbers
            if (wr_reg == REG_CLR1) begin
                clr_req.w1 = wbits & LINE_MASK_W1;
            end
            if (wr_reg == REG_CLR4) begin
                clr_req.w4 = wbits & LINE_MASK_W4;
            end
        end
        hw_new.w1 = line_event.w1 & LINE_MASK_W1;
        hw_new.w4 = line_event.w4 & LINE_MASK_W4;
        // R2 - only enabled lines not yet pending
        set_ok.w1 = set_req.w1 & line_enable.w1 & ~q.pend.w1;
        set_ok.w4 = set_req.w4 & line_enable.w4 & ~q.pend.w4;
        // R7 - serviced lines keep state; new events win over clears
        clr_ok.w1 = clr_req.w1 & ~line_active.w1 & ~hw_new.w1;
        clr_ok.w4 = clr_req.w4 & ~line_active.w4 & ~hw_new.w4;
        clr_blk.w1 = clr_req.w1 & line_active.w1 & q.pend.w1;
        clr_blk.w4 = clr_req.w4 & line_active.w4 & q.pend.w4;
        evt_new = '0;
        evt_new[EVT_SW_PEND] = |{set_ok.w1, set_ok.w4};
        evt_new[EVT_HW_PEND] = |{hw_new.w1 & ~q.pend.w1, hw_new.w4 & ~q.pend.w4};
        evt_new[EVT_CLR_BLOCKED] = |{clr_blk.w1, clr_blk.w4};
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        // R5 - clear removes the pending state
        d.pend.w1 = (q.pend.w1 | hw_new.w1 | set_ok.w1) & ~clr_ok.w1;
        d.pend.w4 = (q.pend.w4 | hw_new.w4 | set_ok.w4) & ~clr_ok.w4;
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_held = 1'b1;
            d.waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_held = 1'b1;
            d.wdata = s_axi_wdata;
            d.wstrb = s_axi_wstrb;
        end
        d.evt_stat = q.evt_stat;
        if (wr_go) begin
            d.aw_held = 1'b0;
            d.w_held = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = (wr_reg == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
            if (wr_reg == REG_EVT_CLR) begin
                d.evt_stat = q.evt_stat & ~wbits[EVT_W-1:0];
            end
            if (wr_reg == REG_EVT_EN) begin
                d.evt_en = wbits[EVT_W-1:0];
            end
        end
        // New events win over a same-cycle clear
        d.evt_stat = d.evt_stat | evt_new;
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp = RESP_OKAY;
            d.rdata = '0;
            unique case (rd_reg)
                // R4 - live pending state; R8 - set and clear words agree
                REG_SET1, REG_CLR1: d.rdata = q.pend.w1;
                REG_SET4, REG_CLR4: d.rdata = q.pend.w4;
                REG_EVT_STAT: d.rdata[EVT_W-1:0] = q.evt_stat;
                REG_EVT_EN: d.rdata[EVT_W-1:0] = q.evt_en;
                REG_EVT_CLR: d.rdata = '0;
                REG_NONE: d.rresp = RESP_SLVERR;
            endcase
        end
        d.irq = |(d.evt_stat & d.evt_en);
        if (!aclken) begin
            d = q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_go;
        wr_go;
    endsequence

    sequence s_read_take(ipsc_reg_t r);
        aclken && s_axi_arvalid && s_axi_arready && rd_reg == r;
    endsequence

    a_set_word4_lines: assert property ( // R1
        s_write_go ##0 (wr_reg == REG_SET4)
        |=> ((pend_lines.w4 & $past(wbits & line_enable.w4 & LINE_MASK_W4))
            == $past(wbits & line_enable.w4 & LINE_MASK_W4)))
        else $error("set word 4 did not pend line");

    a_set_disabled_held: assert property ( // R2
        (pend_lines.w4 & ~$past(pend_lines.w4) & ~$past(line_event.w4)
            & ~$past(line_enable.w4)) == '0)
        else $error("disabled line became pending by software");

    a_fall_needs_clear: assert property ( // R3
        $past(aresetn)
        |-> ((~pend_lines.w1 & $past(pend_lines.w1)) & ~$past(clr_req.w1)) == '0)
        else $error("pending line fell without a clear");

    a_read_live_set4: assert property ( // R4
        s_read_take(REG_SET4) |=> s_axi_rvalid && s_axi_rdata == $past(pend_lines.w4))
        else $error("set word 4 read not live");

    a_clear_drops: assert property ( // R5
        s_write_go ##0 (wr_reg == REG_CLR4)
        |=> ((pend_lines.w4 & $past(wbits & ~line_active.w4 & ~line_event.w4))
            == '0))
        else $error("clear did not remove pending line");

    a_clr_word1_map: assert property ( // R6
        s_write_go ##0 (wr_reg == REG_CLR1) ##0 (wbits[30] && !line_active.w1[30]
            && !line_event.w1[30]) |=> !pend_lines.w1[30] ##1 !pend_lines.w1[30]
            || $past(line_event.w1[30]) || $past(set_req.w1[30]))
        else $error("clear word 1 bit 30 did not clear line 30");

    a_active_kept: assert property ( // R7
        $past(aresetn)
        |-> ((~pend_lines.w1 & $past(pend_lines.w1) & $past(line_active.w1)) == '0)
        && ((~pend_lines.w4 & $past(pend_lines.w4) & $past(line_active.w4)) == '0))
        else $error("serviced line lost pending state");

    a_same_vector: assert property ( // R8
        s_read_take(REG_CLR1) |=> s_axi_rdata == $past(pend_lines.w1)
            && (s_axi_rdata & ~LINE_MASK_W1) == '0)
        else $error("clear word 1 read differs from pending vector");

    // Hardware request on an implemented line of word 4
    sequence s_hw_request;
        aclken && ((line_event.w4 & LINE_MASK_W4) != '0);
    endsequence

    a_hw_event_pends: assert property (
        s_hw_request |=> ((pend_lines.w4 & $past(line_event.w4 & LINE_MASK_W4))
            == $past(line_event.w4 & LINE_MASK_W4)))
        else $error("hardware request did not pend line");

    a_unused_bits_zero: assert property ( // R4
        (pend_lines.w1 & ~LINE_MASK_W1) == '0 && (pend_lines.w4 & ~LINE_MASK_W4) == '0)
        else $error("unimplemented pending bit set");

    a_zero_write_idle: assert property ( // R3
        s_write_go ##0 (wbits == '0)
        |=> pend_lines == $past(pend_lines | hw_new))
        else $error("zero write changed pending state");

    a_clear_blocked_flag: assert property ( // R7
        s_write_go ##0 (wr_reg == REG_CLR1)
            ##0 ((wbits & line_active.w1 & pend_lines.w1) != '0)
        |=> q.evt_stat[EVT_CLR_BLOCKED])
        else $error("refused clear not flagged");

    a_frozen_state: assert property (
        !aclken |=> $stable(pend_lines) && $stable(s_axi_rvalid) && $stable(s_axi_bvalid))
        else $error("state moved while clock enable low");

    a_bresp_follows: assert property (
        s_write_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");

    a_irq_level: assert property (
        ##1 $past(aclken) |-> irq == |(q.evt_stat & q.evt_en))
        else $error("interrupt level wrong");

endmodule

// >>> src/ipsc_pkg.sv
// Constants, register map and carrier types of the pending set/clear block
package ipsc_pkg;

    // ------------------------------------------------------------
    // Bus and event status widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int EVT_W = 3;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_SET_WORD1 = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SET_WORD4 = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_CLR_WORD1 = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_CLR_WORD4 = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_EVT_CLEAR = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_EVT_ENABLE = 8'h18;

    // ------------------------------------------------------------
    // Implemented lines: word 1 holds lines 30..14 and 7..0, word 4 lines 99..98
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] LINE_MASK_W1 = 32'h7fffc0ff;
    localparam logic [DATA_W-1:0] LINE_MASK_W4 = 32'h0000000c;

    // ------------------------------------------------------------
    // Event status bit positions and response codes
    // ------------------------------------------------------------
    localparam int EVT_SW_PEND = 0;
    localparam int EVT_HW_PEND = 1;
    localparam int EVT_CLR_BLOCKED = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        REG_SET1, REG_SET4, REG_CLR1, REG_CLR4,
        REG_EVT_STAT, REG_EVT_CLR, REG_EVT_EN, REG_NONE
    } ipsc_reg_t;

    // One bit per interrupt line of the two covered words
    typedef struct packed {
        logic [DATA_W-1:0] w1;
        logic [DATA_W-1:0] w4;
    } ipsc_lines_t;

    typedef struct packed {
        logic aw_held;
        logic w_held;
        logic [ADDR_W-1:0] waddr;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
        ipsc_lines_t pend;
        logic [EVT_W-1:0] evt_stat;
        logic [EVT_W-1:0] evt_en;
        logic irq;
    } ipsc_state_t;

    localparam ipsc_state_t STATE_RST = '0;

endpackage

// >>> verif/interrupt_pending_set_clear_bench.sv
// Self-checking bench for the pending set/clear block
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module interrupt_pending_set_clear_bench
    import ipsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic aclk, aresetn, aclken, irq;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    ipsc_lines_t line_event, line_enable, line_active, pend_lines;
    int bad_count = 0;
    int comparisons = 0;
    int cyc = 0;

    ipsc_pending dut_u (.aclk, .aresetn, .aclken, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .line_event, .line_enable, .line_active, .pend_lines, .irq);

    ipsc_core_model m_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            input logic [1:0] er);
        logic [1:0] r;
        m_u.write_word(a, d, r);
        `CHK("bresp", er, r)
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
            input logic [1:0] er);
        logic [DATA_W-1:0] d;
        logic [1:0] r;
        m_u.read_word(a, d, r);
        `CHK("rdata", e, d)
        `CHK("rresp", er, r)
    endtask

    // Registered level settles on the same edge as the status bits; two edges are waited
    task automatic irq_is(input logic e);
        repeat (2) @(negedge aclk);
        `CHK("irq", e, irq)
    endtask

    initial begin
        {aresetn, s_axi_awprot, s_axi_arprot} = '0;
        aclken = 1'b1;
        {line_event, line_enable, line_active} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_SET_WORD4, 32'h0, RESP_OKAY);
        wr(OFS_EVT_ENABLE, 32'h7, RESP_OKAY);
        line_enable.w4 <= 32'h4;
        wr(OFS_SET_WORD4, 32'hc, RESP_OKAY);
        rd(OFS_SET_WORD4, 32'h4, RESP_OKAY);
        rd(OFS_CLR_WORD4, 32'h4, RESP_OKAY);
        rd(OFS_EVT_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_EVT_CLEAR, 32'h1, RESP_OKAY);
        line_enable.w4 <= 32'hc;
        wr(OFS_SET_WORD4, 32'h4, RESP_OKAY);
        rd(OFS_EVT_STATUS, 32'h0, RESP_OKAY);
        wr(OFS_SET_WORD4, 32'h0, RESP_OKAY);
        wr(OFS_CLR_WORD4, 32'h0, RESP_OKAY);
        rd(OFS_SET_WORD4, 32'h4, RESP_OKAY);
        wr(OFS_SET_WORD4, 32'h8, RESP_OKAY);
        wr(OFS_CLR_WORD4, 32'h4, RESP_OKAY);
        rd(OFS_SET_WORD4, 32'h8, RESP_OKAY);
        wr(OFS_CLR_WORD4, 32'h8, RESP_OKAY);
        wr(OFS_EVT_CLEAR, 32'h7, RESP_OKAY);
        line_event.w4 <= 32'h8;
        @(posedge aclk);
        line_event.w4 <= '0;
        rd(OFS_SET_WORD4, 32'h8, RESP_OKAY);
        rd(OFS_EVT_STATUS, 32'h2, RESP_OKAY);
        irq_is(1'b1);
        wr(OFS_EVT_ENABLE, 32'h0, RESP_OKAY);
        irq_is(1'b0);
        wr(OFS_EVT_CLEAR, 32'h7, RESP_OKAY);
        line_enable.w1 <= '1;
        wr(OFS_SET_WORD1, 32'hffffffff, RESP_OKAY);
        rd(OFS_CLR_WORD1, LINE_MASK_W1, RESP_OKAY);
        @(negedge aclk);
        `CHK("pend_w1", LINE_MASK_W1, pend_lines.w1)
        wr(OFS_CLR_WORD1, 32'h40004000, RESP_OKAY);
        rd(OFS_SET_WORD1, 32'h3fff80ff, RESP_OKAY);
        line_active.w1 <= 32'h00100000;
        wr(OFS_EVT_ENABLE, 32'h4, RESP_OKAY);
        wr(OFS_CLR_WORD1, 32'h00100000, RESP_OKAY);
        rd(OFS_SET_WORD1, 32'h3fff80ff, RESP_OKAY);
        rd(OFS_EVT_STATUS, 32'h5, RESP_OKAY);
        irq_is(1'b1);
        wr(OFS_EVT_CLEAR, 32'h4, RESP_OKAY);
        irq_is(1'b0);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        aclken <= 1'b0;
        line_event.w4 <= 32'h4;
        repeat (3) @(posedge aclk);
        aclken <= 1'b1;
        line_event.w4 <= '0;
        rd(OFS_SET_WORD4, 32'h8, RESP_OKAY);
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        rd(OFS_SET_WORD4, 32'h0, RESP_OKAY);
        rd(OFS_EVT_ENABLE, 32'h0, RESP_OKAY);
        test_done();
    end
endmodule

// >>> verif/ipsc_core_model.sv
// Processor core model issuing register reads and writes
module ipsc_core_model
    import ipsc_pkg::*;
(
    input wire logic aclk,
    output logic [ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [DATA_W-1:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
    end

    // Each channel held until its own ready; edge gap avoids double drive
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
            output logic [1:0] r);
        bit done;
        @(posedge aclk);
        done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
            output logic [1:0] r);
        bit done;
        @(posedge aclk);
        done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
    endtask
endmodule
